// ==== sdp_err_ctrl.sv ====
// sdp_err_ctrl.sv: debug port target error and buffer logic
//
// Strobed register access and the register addresses were decided locally.
`include "sdp_cfg.svh"
`timescale 1ns/10ps
module sdp_err_ctrl #(
    parameter int          WB_DEPTH   = 4,
    parameter logic        PROTO_V2   = 1'b1,
    parameter logic        IDR_EXIT   = 1'b1,
    parameter logic [3:0]  PERR_LIMIT = 4'h1,
    parameter logic [31:0] IDR_VALUE  = 32'h0000_0001
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        swclkPin,
    input  wire logic        swdioIn,
    output logic             swdioOut,
    output logic             swdioOe,
    input  wire logic [1:0]  turnSetting,
    input  wire logic        pushedEn,
    output logic             apReq,
    output logic             apWr,
    output logic [1:0]       apAddr,
    output logic [31:0]      apWdata,
    input  wire logic        apDone,
    input  wire logic [31:0] apRdata,
    input  wire logic        apErr,
    output logic [1:0]       linkState,
    output logic [2:0]       stickyFlags
);
    import sdp_pkg::*;

    localparam int WB_AW = $clog2(WB_DEPTH);
    localparam int PW    = WB_AW + 1;

    // IDR_VALUE default is arbitrary

    typedef struct packed {
        logic          sck1;
        logic          sck2;
        logic          sck3;
        logic          sd1;
        logic          sd2;
        sdp_phase_e    phase;
        sdp_err_e      err;
        logic [5:0]    cnt;
        logic [5:0]    hdr;
        logic [2:0]    ack;
        logic [32:0]   sh;
        logic          isAp;
        logic          isRd;
        logic          pushW;
        logic          okRsp;
        logic [1:0]    addr;
        logic          toPerr;
        logic          armed;
        logic          first;
        logic [5:0]    ones;
        logic [3:0]    perrCnt;
        logic          orunDet;
        logic          orun;
        logic          stkErr;
        logic          wdErr;
        logic [31:0]   readBuf;
        logic          out;
        logic          oe;
        logic          apReq;
        logic          apWr;
        logic [1:0]    apAddr;
        logic [31:0]   apWdata;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic          fresh;
    } sdp_state_s;

    sdp_state_s    s;
    sdp_state_s    n;
    logic          rise;
    logic          din;
    logic [6:0]    h;
    logic          hAp;
    logic          hRd;
    logic [1:0]    hA;
    logic          perr;
    logic          rdEff;
    logic          idrRd;
    logic          csRd;
    logic          abortWr;
    logic          tselWr;
    logic          neverStall;
    logic          busy;
    logic          stickyAny;
    logic [PW-1:0] wbCount;
    logic          wbEmpty;
    logic          wbFull;
    logic [32:0]   wrWord;
    logic [33:0]   wbHead;
    logic          hdrDone;
    logic          wrDone;
    logic          lineRst;
    logic          push;
    logic          pop;
    logic          flush;
    logic [2:0]    rspAck;
    logic [31:0]   csWord;
    logic [31:0]   rdWord;

    // Parity of a data word
    function automatic logic sdp_par(input logic [31:0] w);
        return ^w;
    endfunction

    // ********
    // Link sampling and header decode
    // ********

    // Rising edge of the synchronised link clock
    assign rise = s.sck2 & ~s.sck3;
    assign din  = s.sd2;

    // Header bits: unit, read, address, parity, stop, park
    assign h       = {din, s.hdr};
    assign hAp     = h[0];
    assign hRd     = h[1];
    assign hA      = h[3:2];
    assign perr    = ((^h[3:0]) != h[4]) | h[5] | ~h[6]
                     | (turnSetting != `SDP_TRN_SUP);
    assign rdEff   = hRd | (hAp & pushedEn);
    assign idrRd   = ~hAp & hRd & (hA == `SDP_A_IDR);
    assign csRd    = ~hAp & hRd & (hA == `SDP_A_CS);
    assign abortWr = ~hAp & ~hRd & (hA == `SDP_A_ABORT);
    assign tselWr  = PROTO_V2 & ~hAp & ~hRd & (hA == `SDP_A_TSEL);
    assign neverStall = idrRd | csRd | abortWr;

    // Buffer fill state
    assign wbCount   = s.wrPtr - s.rdPtr;
    assign wbEmpty   = (wbCount == '0);
    assign wbFull    = wbCount[WB_AW];
    assign stickyAny = s.orun | s.stkErr | s.wdErr;

    // Stall decision per request kind
    assign busy = hAp ? (rdEff ? (~wbEmpty | s.apReq) : wbFull)
                      : (~wbEmpty | s.apReq);

    // Incoming write word, parity in the top bit
    assign wrWord  = {din, s.sh[32:1]};
    assign lineRst = rise & ~s.oe & din & (s.ones == `SDP_LRST_M1);

    // ********
    // Write buffer storage
    // ********

    sdp_wbuf_mem #(
        .WIDTH (34),
        .DEPTH (WB_DEPTH),
        .AW    (WB_AW)
    ) u_wbuf (
        .clk    (clk),
        .rst_n  (rst_n),
        .wrEn   (push),
        .wrAddr (s.wrPtr[WB_AW-1:0]),
        .wrData ({s.addr, wrWord[31:0]}),
        .rdAddr (s.rdPtr[WB_AW-1:0]),
        .rdData (wbHead)
    );

    // ********
    // Next state
    // ********

    always_comb
    begin
        n       = s;
        hdrDone = 1'b0;
        wrDone  = 1'b0;
        push    = 1'b0;
        pop     = 1'b0;
        flush   = 1'b0;
        rspAck  = `SDP_ACK_OK;
        csWord  = '0;
        csWord[`SDP_CS_ORUNDET] = s.orunDet;
        csWord[`SDP_CS_ORUN]    = s.orun;
        csWord[`SDP_CS_STKERR]  = s.stkErr;
        csWord[`SDP_CS_WDERR]   = s.wdErr;
        rdWord  = idrRd ? IDR_VALUE : (csRd ? csWord : s.readBuf);

        // Two-stage synchronisers for link pins
        n.sck1 = swclkPin;
        n.sck2 = s.sck1;
        n.sck3 = s.sck2;
        n.sd1  = swdioIn;
        n.sd2  = s.sd1;

        // Count host-driven ones for line reset
        if (rise && !s.oe)
        begin
            if (!din)
            begin
                n.ones = '0;
            end
            else if (s.ones != `SDP_LRST_BITS)
            begin
                n.ones = s.ones + 6'h01;
            end
        end

        // Bit phase sequencer
        if (rise)
        begin
            unique case (s.phase)
                SDP_IDLE:
                begin
                    if (!din)
                    begin
                        n.armed = 1'b1;
                    end
                    else if (s.armed && s.err != SDP_LOCK)
                    begin
                        n.phase = SDP_HDR;
                        n.cnt   = '0;
                    end
                end
                SDP_HDR:
                begin
                    if (s.cnt != `SDP_HDR_LAST)
                    begin
                        n.hdr = {din, s.hdr[5:1]};
                        n.cnt = s.cnt + 6'h01;
                    end
                    else
                    begin
                        hdrDone = 1'b1;
                    end
                end
                SDP_TRN:
                begin
                    n.phase = SDP_ACK;
                    n.cnt   = '0;
                    n.oe    = 1'b1;
                    n.out   = s.ack[0];
                    n.ack   = {1'b0, s.ack[2:1]};
                end
                SDP_ACK:
                begin
                    if (s.cnt != `SDP_ACK_LAST)
                    begin
                        n.out = s.ack[0];
                        n.ack = {1'b0, s.ack[2:1]};
                        n.cnt = s.cnt + 6'h01;
                    end
                    else if (s.okRsp && s.isRd && !s.pushW)
                    begin
                        n.phase = SDP_RDAT;
                        n.cnt   = '0;
                        n.out   = s.sh[0];
                        n.sh    = {1'b0, s.sh[32:1]};
                    end
                    else
                    begin
                        n.oe  = 1'b0;
                        n.out = 1'b0;
                        n.cnt = s.orunDet ? `SDP_SKIP_DUMMY : `SDP_SKIP_TRN;
                        n.phase = s.okRsp ? SDP_WTRN : SDP_SKIP;
                    end
                end
                SDP_RDAT:
                begin
                    if (s.cnt != `SDP_DATA_LAST)
                    begin
                        n.out = s.sh[0];
                        n.sh  = {1'b0, s.sh[32:1]};
                        n.cnt = s.cnt + 6'h01;
                    end
                    else
                    begin
                        n.oe    = 1'b0;
                        n.out   = 1'b0;
                        n.phase = SDP_SKIP;
                        n.cnt   = `SDP_SKIP_TRN;
                    end
                end
                SDP_WTRN:
                begin
                    n.phase = SDP_WDAT;
                    n.cnt   = '0;
                end
                SDP_WDAT:
                begin
                    n.sh = wrWord;
                    if (s.cnt != `SDP_DATA_LAST)
                    begin
                        n.cnt = s.cnt + 6'h01;
                    end
                    else
                    begin
                        wrDone  = 1'b1;
                        n.phase = SDP_IDLE;
                        n.armed = 1'b1;
                    end
                end
                SDP_SKIP:
                begin
                    if (s.cnt == '0)
                    begin
                        n.phase  = SDP_IDLE;
                        n.armed  = 1'b1;
                        n.toPerr = 1'b0;
                        if (s.toPerr)
                        begin
                            n.err = SDP_PERR;
                        end
                    end
                    else
                    begin
                        n.cnt = s.cnt - 6'h01;
                    end
                end
            endcase
        end

        // Header evaluation
        if (hdrDone)
        begin
            n.first = 1'b0;
            n.armed = 1'b0;
            n.phase = SDP_IDLE;
            if (perr)
            begin
                if (s.orunDet)
                begin
                    n.orun = 1'b1;
                end
                if ((PROTO_V2 && s.first) ||
                    (s.err == SDP_PERR && (s.perrCnt + 4'h1) >= PERR_LIMIT))
                begin
                    n.err = SDP_LOCK;
                end
                else if (s.err == SDP_PERR)
                begin
                    n.perrCnt = s.perrCnt + 4'h1;
                end
                else if (s.orunDet)
                begin
                    n.phase  = SDP_SKIP;
                    n.cnt    = `SDP_SKIP_HDR;
                    n.toPerr = 1'b1;
                end
                else
                begin
                    n.err = SDP_PERR;
                end
            end
            else if (s.err == SDP_PERR && !(idrRd && IDR_EXIT))
            begin
                n.err = SDP_LOCK;
            end
            else if (tselWr)
            begin
                n.phase = SDP_SKIP;
                n.cnt   = `SDP_SKIP_HDR;
            end
            else
            begin
                if (s.err == SDP_PERR)
                begin
                    n.err     = SDP_NORMAL;
                    n.perrCnt = '0;
                end
                if (neverStall)
                begin
                    if (!wbEmpty)
                    begin
                        flush   = 1'b1;
                        n.wdErr = 1'b1;
                    end
                end
                else if (stickyAny)
                begin
                    rspAck = `SDP_ACK_FAULT;
                    if (s.orunDet)
                    begin
                        n.orun = 1'b1;
                    end
                end
                else if (busy)
                begin
                    rspAck = `SDP_ACK_WAIT;
                    if (s.orunDet)
                    begin
                        n.orun = 1'b1;
                    end
                end
                n.isAp  = hAp;
                n.isRd  = rdEff;
                n.pushW = hAp & ~hRd & pushedEn;
                n.addr  = hA;
                n.ack   = rspAck;
                n.okRsp = (rspAck == `SDP_ACK_OK);
                n.sh    = {sdp_par(rdWord), rdWord};
                n.phase = SDP_TRN;
                // Posted unit read starts at once
                if (rspAck == `SDP_ACK_OK && hAp && hRd)
                begin
                    n.apReq  = 1'b1;
                    n.apWr   = 1'b0;
                    n.apAddr = hA;
                end
            end
        end

        // Write data phase complete
        if (wrDone)
        begin
            if (sdp_par(wrWord[31:0]) != wrWord[32])
            begin
                n.wdErr = 1'b1;
            end
            else if (!s.isAp && s.addr == `SDP_A_ABORT)
            begin
                if (wrWord[`SDP_AB_ORUNCLR])
                begin
                    n.orun = 1'b0;
                end
                if (wrWord[`SDP_AB_WDCLR])
                begin
                    n.wdErr = 1'b0;
                end
                if (wrWord[`SDP_AB_STKCLR])
                begin
                    n.stkErr = 1'b0;
                end
            end
            else if (!s.isAp && s.addr == `SDP_A_CS)
            begin
                n.orunDet = wrWord[`SDP_CS_ORUNDET];
            end
            else if (s.isAp && s.pushW)
            begin
                n.apReq  = 1'b1;
                n.apWr   = 1'b0;
                n.apAddr = s.addr;
            end
            else if (s.isAp)
            begin
                push = 1'b1;
            end
        end

        // Sticky flag abandons buffered writes
        if (stickyAny && !wbEmpty)
        begin
            flush   = 1'b1;
            n.wdErr = 1'b1;
        end

        // Unit access completion
        if (s.apReq && apDone)
        begin
            n.apReq = 1'b0;
            if (!s.apWr)
            begin
                n.readBuf = apRdata;
            end
            if (apErr)
            begin
                n.stkErr = 1'b1;
            end
        end

        // Drain buffer head in order
        if (!s.apReq && !n.apReq && !wbEmpty && !s.fresh && !flush)
        begin
            pop       = 1'b1;
            n.apReq   = 1'b1;
            n.apWr    = 1'b1;
            n.apAddr  = wbHead[33:32];
            n.apWdata = wbHead[31:0];
        end

        // Buffer pointers
        if (flush)
        begin
            n.rdPtr = s.wrPtr;
        end
        else if (pop)
        begin
            n.rdPtr = s.rdPtr + 1'b1;
        end
        if (push)
        begin
            n.wrPtr = s.wrPtr + 1'b1;
        end
        n.fresh = push | pop | flush;

        // Line reset recovers from every state
        if (lineRst)
        begin
            n.phase   = SDP_IDLE;
            n.armed   = 1'b0;
            n.oe      = 1'b0;
            n.out     = 1'b0;
            n.err     = SDP_NORMAL;
            n.perrCnt = '0;
            n.toPerr  = 1'b0;
            n.first   = 1'b1;
            if (s.orunDet)
            begin
                n.orun = 1'b1;
            end
        end
    end

    // ********
    // State register and outputs
    // ********

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    // Outputs straight from state
    assign swdioOut    = s.out;
    assign swdioOe     = s.oe;
    assign apReq       = s.apReq;
    assign apWr        = s.apWr;
    assign apAddr      = s.apAddr;
    assign apWdata     = s.apWdata;
    assign linkState   = s.err;
    assign stickyFlags = {s.wdErr, s.stkErr, s.orun};

endmodule

// ==== sdp_cfg.svh ====
// sdp_cfg.svh: link counts, codes and bit positions
// Summary of operation
// - A malformed packet request moves the target into the protocol-error state.
// - With overrun detection, error sets overrun flag; state entered after data phase.
// - After a protocol error the target sends no acknowledge and leaves the line free.
// - Version 2: a target-selection register write gets no acknowledge either.
// - In error state a valid identification read may exit the state with OK.
// - In error state other valid headers or more errors lead to lockout.
// - Preferred: lockout after one further protocol error in the error state.
// - A line reset always leaves the protocol-error state.
// - Lockout is left only by a line reset.
// - Version 2: one protocol error straight after line reset causes lockout.
// - Request before previous completes gets WAIT; overrun flag set if enabled.
// - With overrun detection, FAULT, protocol error and line reset set overrun.
// - With overrun detection WAIT and FAULT get a data phase, line undriven.
// - OK to a buffered write means only that the write entered the buffer.
// - All accesses happen in order; port writes other than abort stall while buffer holds writes.
// - Abandoned buffered write sets write-data error; sticky flags abandon buffer.
// - Identification and status reads never stall; they discard buffer, set error.
// - Abort writes never stall; pending buffered writes are abandoned.
// - With buffer not empty, unit reads and stallable port accesses get WAIT.
// - Pushed modes turn unit writes into unit reads, stalled like reads.
// - Protocol error: bad parity, stop not 0, park not 1, bad turnaround.
// - OK acknowledge is the three-bit value 0b001 on the line.
// - Any set sticky flag gives FAULT except the three never-stalled accesses.
// - Abort register bits clear the sticky flags to 0.
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH

// Acknowledge codes, first bit on the line is bit 0
`define SDP_ACK_OK      3'h1
`define SDP_ACK_WAIT    3'h2
`define SDP_ACK_FAULT   3'h4

// Bit counts on the link
`define SDP_LRST_BITS   6'h32
`define SDP_LRST_M1     6'h31
`define SDP_HDR_LAST    6'h06
`define SDP_ACK_LAST    6'h02
`define SDP_DATA_LAST   6'h20
`define SDP_SKIP_HDR    6'h25
`define SDP_SKIP_DUMMY  6'h21
`define SDP_SKIP_TRN    6'h00

// Port register addresses
`define SDP_A_IDR       2'h0
`define SDP_A_ABORT     2'h0
`define SDP_A_CS        2'h1
`define SDP_A_TSEL      2'h3

// Control/status and abort bit positions
`define SDP_CS_ORUNDET  0
`define SDP_CS_ORUN     1
`define SDP_CS_STKERR   5
`define SDP_CS_WDERR    7
`define SDP_AB_STKCLR   2
`define SDP_AB_WDCLR    3
`define SDP_AB_ORUNCLR  4

// Only turnaround setting supported
`define SDP_TRN_SUP     2'h0

`endif

// ==== sdp_pkg.sv ====
// sdp_pkg.sv: types shared by the serial debug port error logic
package sdp_pkg;

    // Link bit phase
    typedef enum logic [2:0] {
        SDP_IDLE = 3'h0,
        SDP_HDR  = 3'h1,
        SDP_TRN  = 3'h2,
        SDP_ACK  = 3'h3,
        SDP_RDAT = 3'h4,
        SDP_WTRN = 3'h5,
        SDP_WDAT = 3'h6,
        SDP_SKIP = 3'h7
    } sdp_phase_e;

    // Error state of the port
    typedef enum logic [1:0] {
        SDP_NORMAL = 2'h0,
        SDP_PERR   = 2'h1,
        SDP_LOCK   = 2'h2
    } sdp_err_e;

endpackage

// ==== sdp_wbuf_mem.sv ====
// sdp_wbuf_mem.sv: write buffer storage with registered read data
`timescale 1ns/10ps
module sdp_wbuf_mem #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 4,
    parameter int AW    = 2
)(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage write
    always_ff @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    // Registered read port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdData <= '0;
        end
        else
        begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

// ==== sdp_err_ctrl_monitor.sv ====
// sdp_err_ctrl_monitor.sv: assertions on the serial debug port pins and the unit port
`timescale 1ns/10ps
module sdp_err_ctrl_monitor
    import sdp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        swclkPin,
    input wire logic        swdioIn,
    input wire logic        swdioOe,
    input wire logic        apReq,
    input wire logic        apWr,
    input wire logic [1:0]  apAddr,
    input wire logic [31:0] apWdata,
    input wire logic        apDone,
    input wire logic [1:0]  linkState
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ********
    // Link
    // ********
    a_lock_quiet: assert property (linkState == SDP_LOCK |-> !swdioOe)
        else $error("line driven in lockout");
    a_lock_exit: assert property (linkState == SDP_LOCK ##1 linkState != SDP_LOCK
        |-> linkState == SDP_NORMAL && $past(swdioIn, 4)) else $error("lockout left");
    a_state_legal: assert property (linkState != 2'h3) else $error("bad state");
    a_err_no_ack: assert property (linkState != SDP_NORMAL |-> !$rose(swdioOe))
        else $error("ack in error state");
    a_oe_at_rise: assert property ($changed(swdioOe) |-> swclkPin)
        else $error("line turned off clock edge");
    a_ack_held: assert property ($rose(swdioOe) |=> swdioOe [*8]) else $error("short ack");
    // ********
    // Unit port
    // ********
    a_ap_hold: assert property (apReq && !apDone
        |=> apReq && $stable({apWr, apAddr, apWdata})) else $error("unit request moved");
    a_ap_gap: assert property (apReq && apDone |=> !apReq) else $error("unit gap");
    c_perr: cover property (linkState == SDP_PERR);
    c_lock: cover property (linkState == SDP_LOCK);
    c_ap: cover property (apReq && apDone);
endmodule

bind sdp_err_ctrl sdp_err_ctrl_monitor u_mon (.*);

// ==== sdp_ap_model.sv ====
// sdp_ap_model.sv: access unit responder with adjustable latency
`timescale 1ns/10ps
module sdp_ap_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        apReq,
    input  wire logic [11:0] lat,
    output logic             apDone,
    output logic [31:0]      apRdata
);
    logic [11:0] cnt_q;
    // Done lat+1 cycles after request first seen; data churns
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q   <= '0;
            apDone  <= 1'b0;
            apRdata <= '0;
        end
        else
        begin
            apDone  <= apReq && !apDone && cnt_q >= lat;
            cnt_q   <= (apReq && !apDone) ? cnt_q + 12'h1 : 12'h0;
            apRdata <= ~apRdata;
        end
    end
endmodule

// ==== test_serial_debug_error_overrun_wbuf.sv ====
// test_serial_debug_error_overrun_wbuf.sv: self-checking bench for the debug port
`timescale 1ns/10ps
`include "sdp_cfg.svh"
module test_serial_debug_error_overrun_wbuf;
    import sdp_pkg::*;
    localparam logic [31:0] IDV = 32'h0000_5a3c; // Arbitrary identification value
    logic        clk, rst_n, swclkPin, hostBit, hostOe, pushedEn, apDone;
    logic        swdioOut, swdioOe, apReq, apWr, detOn;
    logic [1:0]  turnSetting, apAddr, linkState;
    logic [2:0]  stickyFlags, ack;
    logic [11:0] lat;
    logic [31:0] apWdata, apRdata, rd, seed;
    int          failures = 0, nCompared = 0;
    wire logic   swLine;
    // Data line, pulled up when free
    assign swLine = swdioOe ? swdioOut : (hostOe ? hostBit : 1'b1);
    sdp_err_ctrl #(.WB_DEPTH(2), .IDR_VALUE(IDV)) dut (.*, .swdioIn(swLine), .apErr(1'b0));
    sdp_ap_model u_ap (.*);
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [34:0] got, exp);
        nCompared++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One link period, line sampled before the rise
    task automatic bitp(input logic b, drv, output logic s);
        hostBit <= b;
        hostOe <= drv;
        swclkPin <= 1'b0;
        repeat (10) @(posedge clk);
        s = swLine;
        swclkPin <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    // Line reset
    task automatic lres();
        logic s;
        for (int i = 0; i < 52; i++)
            bitp(i < 50, 1'b1, s);
    endtask
    // Header, ack and data phase
    task automatic xfer(input logic ap, rnw, input logic [1:0] a, input logic [31:0] wd,
        input logic bad);
        logic [7:0] h;
        logic       s;
        h = {2'b10, ap ^ rnw ^ a[0] ^ a[1] ^ bad, a[1], a[0], rnw, ap, 1'b1};
        for (int i = 0; i < 12; i++)
        begin
            bitp(h[i % 8], i < 8, s);
            if (i > 8) ack[i - 9] = s;
        end
        if (ack == `SDP_ACK_OK || detOn && ack inside {`SDP_ACK_WAIT, `SDP_ACK_FAULT})
            for (int i = 0; i < 34; i++)
            begin
                bitp(i == 33 ? ^wd : wd[(i + 31) % 32], !rnw && i > 0, s);
                if (i < 32) rd[i] = s;
            end
        else if (ack != 3'h7)
            bitp(1'b0, 1'b0, s);
        else
            repeat (34) bitp(1'b0, 1'b0, s);
        repeat (2) bitp(1'b0, 1'b1, s);
    endtask
    initial
    begin
        {rst_n, swclkPin, hostBit, hostOe, pushedEn, detOn, turnSetting, lat} = '0;
        seed = 32'h0000_b24b;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        lres();
        // Error states
        xfer(0, 1, 2'h0, 0, 0);
        check("idr", {ack, rd}, {`SDP_ACK_OK, IDV});
        xfer(0, 1, 2'h0, 0, 1);
        check("perr", {ack, linkState}, {3'h7, SDP_PERR});
        xfer(0, 1, 2'h0, 0, 0);
        check("exit", {ack, linkState}, {`SDP_ACK_OK, SDP_NORMAL});
        xfer(0, 1, 2'h1, 0, 1);
        xfer(1, 1, 2'h1, 0, 0);
        check("hdr lock", linkState, SDP_LOCK);
        lres();
        check("lres", linkState, SDP_NORMAL);
        xfer(0, 1, 2'h0, 0, 0);
        xfer(0, 0, 2'h1, 0, 1);
        xfer(0, 0, 2'h1, 0, 1);
        check("err lock", linkState, SDP_LOCK);
        xfer(0, 1, 2'h0, 0, 0);
        check("lock", {ack, linkState}, {3'h7, SDP_LOCK});
        lres();
        turnSetting <= 2'h1;
        xfer(0, 1, 2'h0, 0, 0);
        check("v2 lock", linkState, SDP_LOCK);
        turnSetting <= 2'h0;
        lres();
        xfer(0, 0, 2'h3, rnd(), 0);
        check("tsel", ack, 3'h7);
        lres();
        // Write buffer
        lat <= 12'hfff;
        xfer(1, 0, 2'h1, rnd(), 0);
        check("wb1", ack, `SDP_ACK_OK);
        xfer(1, 0, 2'h2, rnd(), 0);
        check("wb2", ack, `SDP_ACK_OK);
        xfer(0, 0, 2'h2, rnd(), 0);
        check("dp stall", ack, `SDP_ACK_WAIT);
        xfer(1, 1, 2'h0, 0, 0);
        check("ap stall", ack, `SDP_ACK_WAIT);
        pushedEn <= 1'b1;
        xfer(1, 0, 2'h1, rnd(), 0);
        check("pushed", ack, `SDP_ACK_WAIT);
        pushedEn <= 1'b0;
        xfer(0, 1, 2'h1, 0, 0);
        check("cs read", {ack, stickyFlags}, {`SDP_ACK_OK, 3'h4});
        xfer(1, 0, 2'h0, rnd(), 0);
        check("fault", ack, `SDP_ACK_FAULT);
        xfer(0, 0, 2'h0, 32'h0000_0008, 0);
        check("abort", {ack, stickyFlags}, {`SDP_ACK_OK, 3'h0});
        lat <= 12'(rnd() % 16);
        for (int i = 0; i < 5000 && apReq; i++) @(posedge clk);
        // Overrun
        xfer(0, 0, 2'h1, 32'h0000_0001, 0);
        detOn = 1'b1;
        lat <= 12'hfff;
        xfer(1, 1, 2'h0, 0, 0);
        xfer(1, 1, 2'h1, 0, 0);
        check("orun", {ack, stickyFlags}, {`SDP_ACK_WAIT, 3'h1});
        check("orun data", rd, 32'hffff_ffff);
        xfer(0, 1, 2'h2, 0, 0);
        check("orun fault", {ack, rd}, {`SDP_ACK_FAULT, 32'hffff_ffff});
        xfer(0, 0, 2'h0, 32'h0000_0010, 0);
        check("orun clr", stickyFlags, 3'h0);
        xfer(0, 1, 2'h0, 0, 1);
        check("orun perr", {linkState, stickyFlags}, {SDP_PERR, 3'h1});
        xfer(0, 0, 2'h0, 32'h0000_0010, 0);
        lres();
        check("orun lres", {linkState, stickyFlags}, {SDP_NORMAL, 3'h1});
        finish_test();
    end
    // Watchdog
    initial
    begin
        #380000;
        failures++;
        finish_test();
    end
endmodule
